// [design/stepper_defs.vh]
`ifndef STEPPER_DEFS_VH
`define STEPPER_DEFS_VH
// Five phases; ten half-step states per electrical cycle (3.6 degrees).
`define NUM_PHASES 5
`define IDX_W 4
`define IDX_LAST 4'h9
`define IDX_ZERO 4'h0
`define IDX_ONE 4'h1
`define IDX_TWO 4'h2
// Microstep division, 1..250, eight bits.
`define DIV_W 8
`define DIV_MAX 8'hfa
`define DIV_MIN 8'h01
// Position counts in sub-steps; deviation signed.
`define POS_W 24
`define DEV_W 24
`define DEV_ZERO 24'h000000
// Threshold 1.8 degrees = 2.5 full steps = 5 half-step states, scaled by division.
`define THRESH_HALF_STEPS 8'h05
// Velocity filter: 16 settings, filter code 4 bits.
`define VF_W 4
`define VF_ZERO 4'h0
`define VF_CNT_W 16
`define VF_CNT_ZERO 16'h0000
`define VF_SHIFT_BASE 4'h6
`endif

// [design/phase_pattern.v]
`default_nettype none
`include "stepper_defs.vh"
// Maps a half-step index to the five winding enables.
// Even indices energize four phases, odd indices all five.
module phase_pattern (
   input wire i_core_clk,
   input wire i_rst,
   input wire [`IDX_W-1:0] i_index,
   output reg [`NUM_PHASES-1:0] o_phases
);
   reg [`NUM_PHASES-1:0] pat_d;
   always @* begin
      case (i_index)
         4'h0: pat_d = 5'h1e;
         4'h1: pat_d = 5'h1f;
         4'h2: pat_d = 5'h1d;
         4'h3: pat_d = 5'h1f;
         4'h4: pat_d = 5'h1b;
         4'h5: pat_d = 5'h1f;
         4'h6: pat_d = 5'h17;
         4'h7: pat_d = 5'h1f;
         4'h8: pat_d = 5'h0f;
         4'h9: pat_d = 5'h1f;
         default: pat_d = 5'h1e;
      endcase
   end
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_phases <= 5'h1e;
      end else begin
         o_phases <= pat_d;
      end
   end
endmodule
`default_nettype wire

// [design/velocity_filter.v]
`default_nettype none
`include "stepper_defs.vh"
// Smooths the step request: pulses are accumulated and released at a
// rate limited by a minimum gap of i_setting times 64 cycles between
// releases. Setting 0 passes pulses straight through. Pulses are delayed,
// but one against the queued direction, or still queued when setting 0 is chosen, is lost.
module velocity_filter (
   input wire i_core_clk,
   input wire i_rst,
   input wire [`VF_W-1:0] i_setting,
   input wire i_step,
   input wire i_dir,
   output reg o_step,
   output reg o_dir
);
   reg [`VF_CNT_W-1:0] pend_q;
   reg [`VF_CNT_W-1:0] gap_q;
   reg [`VF_CNT_W-1:0] gap_lim;
   reg last_dir_q;
   wire release_ok;
   always @* begin
      gap_lim = {{(`VF_CNT_W-`VF_W){1'b0}}, i_setting} << `VF_SHIFT_BASE;
   end
   assign release_ok = (pend_q != `VF_CNT_ZERO) && (gap_q >= gap_lim);
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         pend_q <= `VF_CNT_ZERO;
         gap_q <= `VF_CNT_ZERO;
         last_dir_q <= 1'b0;
         o_step <= 1'b0;
         o_dir <= 1'b0;
      end else if (i_setting == `VF_ZERO) begin
         pend_q <= `VF_CNT_ZERO;
         gap_q <= `VF_CNT_ZERO;
         o_step <= i_step;
         o_dir <= i_dir;
      end else begin
         // A direction change only takes effect once the queue is empty.
         if (i_step && (pend_q == `VF_CNT_ZERO)) begin
            last_dir_q <= i_dir;
         end
         pend_q <= pend_q + {{(`VF_CNT_W-1){1'b0}}, (i_step && (i_dir == last_dir_q || pend_q == `VF_CNT_ZERO))}
            - {{(`VF_CNT_W-1){1'b0}}, release_ok};
         gap_q <= release_ok ? `VF_CNT_ZERO : (gap_q == {`VF_CNT_W{1'b1}} ? gap_q : gap_q + 16'h0001);
         o_step <= release_ok;
         o_dir <= last_dir_q;
      end
   end
endmodule
`default_nettype wire

// [design/stepper_excitation_control.v]
//Contract
//- Full step energizes exactly four phases in open loop; closed loop follows the rotor index.
//- Half step alternates four and five phases.
//- Chopper on below reference, off above.
//- Microstep divides step by 1 to 250.
//- Two independent division settings held.
//- External select picks active division.
//- Deviation equals commanded minus sensed position; a sensed pulse in the same cycle as an opposite-direction step is dropped.
//- Below 1.8 degrees runs open loop.
//- At 1.8 degrees or more closed loop.
//- Closed loop excites from rotor position.
//- Velocity filter with sixteen settings.
//- Half step: one state per pulse; full step: two; microstep: two per division count; reverse reverses.
//- Reset to step zero, flag at zero.
`default_nettype none
`include "stepper_defs.vh"
module stepper_excitation_control (
   input wire i_core_clk,
   input wire i_rst,
   input wire i_step,
   input wire i_dir,
   input wire i_half_step,
   input wire i_microstep_en,
   input wire [`DIV_W-1:0] i_div_setting_a,
   input wire [`DIV_W-1:0] i_div_setting_b,
   input wire i_div_select,
   input wire [`VF_W-1:0] i_vf_setting,
   input wire i_sense_above_ref,
   input wire i_rotor_step,
   input wire i_rotor_dir,
   output reg [`NUM_PHASES-1:0] o_phase_en,
   output reg o_chopper_switch,
   output reg o_excitation_home_flag,
   output reg o_closed_loop,
   output reg [`DEV_W-1:0] o_deviation,
   output reg [`DIV_W-1:0] o_active_div,
   output reg [`DIV_W-1:0] o_sub_step
);
   ////////////////////////////////////////////////////////////////////////
   wire f_step;
   wire f_dir;
   wire [`NUM_PHASES-1:0] pat;
   reg [`IDX_W-1:0] idx_q;
   reg [`IDX_W-1:0] idx_d;
   reg [`IDX_W-1:0] rotor_idx_q;
   reg [`IDX_W-1:0] cl_idx;
   reg [`IDX_W-1:0] sel_idx;
   reg [`DIV_W-1:0] sub_q;
   reg [`DIV_W-1:0] div_a_q;
   reg [`DIV_W-1:0] div_b_q;
   reg [`DIV_W-1:0] div_act;
   reg [`DEV_W-1:0] dev_q;
   reg [`DEV_W-1:0] dev_d;
   reg [`DEV_W-1:0] dev_abs;
   reg [`DEV_W-1:0] thresh;
   reg adv;
   reg cl_q;

   velocity_filter u_vf (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_setting(i_vf_setting),
      .i_step(i_step),
      .i_dir(i_dir),
      .o_step(f_step),
      .o_dir(f_dir)
   );

   ////////////////////////////////////////////////////////////////////////
   // Division settings latched from the switches, clamped to the legal range.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         div_a_q <= `DIV_MIN;
         div_b_q <= `DIV_MIN;
      end else begin
         div_a_q <= (i_div_setting_a == 8'h00) ? `DIV_MIN :
                    (i_div_setting_a > `DIV_MAX) ? `DIV_MAX : i_div_setting_a;
         div_b_q <= (i_div_setting_b == 8'h00) ? `DIV_MIN :
                    (i_div_setting_b > `DIV_MAX) ? `DIV_MAX : i_div_setting_b;
      end
   end

   always @* begin
      div_act = i_microstep_en ? (i_div_select ? div_b_q : div_a_q) : `DIV_MIN;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sub-step counter: a full step is taken after div_act input pulses.
   // Full step moves the index by two half-step states.
   always @* begin
      adv = 1'b0;
      if (f_step) begin
         if (f_dir) begin
            adv = (sub_q == 8'h00) || (sub_q >= div_act);
         end else begin
            adv = (sub_q + 8'h01 >= div_act);
         end
      end
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         sub_q <= 8'h00;
      end else if (f_step) begin
         if (!f_dir) begin
            sub_q <= adv ? 8'h00 : sub_q + 8'h01;
         end else begin
            sub_q <= adv ? div_act - 8'h01 : sub_q - 8'h01;
         end
      end
   end

   always @* begin
      idx_d = idx_q;
      if (adv) begin
         if (!f_dir) begin
            if (i_half_step && !i_microstep_en) begin
               idx_d = (idx_q == `IDX_LAST) ? `IDX_ZERO : idx_q + `IDX_ONE;
            end else begin
               idx_d = (idx_q >= 4'h8) ? idx_q - 4'h8 : idx_q + `IDX_TWO;
            end
         end else begin
            if (i_half_step && !i_microstep_en) begin
               idx_d = (idx_q == `IDX_ZERO) ? `IDX_LAST : idx_q - `IDX_ONE;
            end else begin
               idx_d = (idx_q < `IDX_TWO) ? idx_q + 4'h8 : idx_q - `IDX_TWO;
            end
         end
         // Full step keeps to four-phase states only.
         if (!(i_half_step && !i_microstep_en)) begin
            idx_d = {idx_d[`IDX_W-1:1], 1'b0};
         end
      end
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         idx_q <= `IDX_ZERO;
      end else begin
         idx_q <= idx_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sensed rotor position as a half-step index, moved by sensor pulses.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         rotor_idx_q <= `IDX_ZERO;
      end else if (i_rotor_step) begin
         if (!i_rotor_dir) begin
            rotor_idx_q <= (rotor_idx_q == `IDX_LAST) ? `IDX_ZERO : rotor_idx_q + `IDX_ONE;
         end else begin
            rotor_idx_q <= (rotor_idx_q == `IDX_ZERO) ? `IDX_LAST : rotor_idx_q - `IDX_ONE;
         end
      end
   end

   // Deviation in sub-steps: commanded pulses count up, sensed pulses down.
   always @* begin
      dev_d = dev_q;
      if (f_step && !(i_rotor_step && (i_rotor_dir == f_dir))) begin
         dev_d = f_dir ? dev_q - 24'h000001 : dev_q + 24'h000001;
      end else if (i_rotor_step && !f_step) begin
         dev_d = i_rotor_dir ? dev_q + 24'h000001 : dev_q - 24'h000001;
      end
      dev_abs = dev_q[`DEV_W-1] ? (`DEV_ZERO - dev_q) : dev_q;
      thresh = {16'h0000, `THRESH_HALF_STEPS} * {16'h0000, div_act};
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         dev_q <= `DEV_ZERO;
         cl_q <= 1'b0;
      end else begin
         dev_q <= dev_d;
         cl_q <= (dev_abs >= thresh);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Closed loop: excite two full steps ahead of the rotor toward the command,
   // which sits at the torque peak and clear of the unstable point.
   always @* begin
      if (dev_q[`DEV_W-1]) begin
         cl_idx = (rotor_idx_q < 4'h4) ? rotor_idx_q + 4'h6 : rotor_idx_q - 4'h4;
      end else begin
         cl_idx = (rotor_idx_q > 4'h5) ? rotor_idx_q - 4'h6 : rotor_idx_q + 4'h4;
      end
      sel_idx = cl_q ? cl_idx : idx_q;
   end

   phase_pattern u_pat (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_index(sel_idx),
      .o_phases(pat)
   );

   ////////////////////////////////////////////////////////////////////////
   // Chopper comparison is registered; a one-cycle lag is harmless against
   // the winding time constant and keeps the output glitch free.
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_phase_en <= 5'h1e;
         o_chopper_switch <= 1'b0;
         o_excitation_home_flag <= 1'b1;
         o_closed_loop <= 1'b0;
         o_deviation <= `DEV_ZERO;
         o_active_div <= `DIV_MIN;
         o_sub_step <= 8'h00;
      end else begin
         o_phase_en <= pat;
         o_chopper_switch <= !i_sense_above_ref;
         o_excitation_home_flag <= (idx_q == `IDX_ZERO) && (sub_q == 8'h00);
         o_closed_loop <= cl_q;
         o_deviation <= dev_q;
         o_active_div <= div_act;
         o_sub_step <= sub_q;
      end
   end
endmodule
`default_nettype wire

// [bench/stepper_excitation_control_chk.sv]
`default_nettype none
`include "stepper_defs.vh"
module stepper_excitation_control_chk (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_step,
   input wire logic i_dir,
   input wire logic i_half_step,
   input wire logic i_microstep_en,
   input wire logic [`DIV_W-1:0] i_div_setting_a,
   input wire logic [`DIV_W-1:0] i_div_setting_b,
   input wire logic i_div_select,
   input wire logic [`VF_W-1:0] i_vf_setting,
   input wire logic i_sense_above_ref,
   input wire logic i_rotor_step,
   input wire logic i_rotor_dir,
   input wire logic [`NUM_PHASES-1:0] o_phase_en,
   input wire logic o_chopper_switch,
   input wire logic o_excitation_home_flag,
   input wire logic o_closed_loop,
   input wire logic [`DEV_W-1:0] o_deviation,
   input wire logic [`DIV_W-1:0] o_active_div,
   input wire logic [`DIV_W-1:0] o_sub_step
);
   function automatic logic [7:0] clamp_div(input logic [7:0] v);
      clamp_div = (v == 8'h00) ? 8'h01 : ((v > 8'hfa) ? 8'hfa : v);
   endfunction
   wire logic [7:0] exp_div = !i_microstep_en ? 8'h01 :
      (i_div_select ? clamp_div(i_div_setting_b) : clamp_div(i_div_setting_a));
   wire logic [23:0] dev_mag = o_deviation[23] ? -o_deviation : o_deviation;
   wire logic [23:0] thresh = {16'h0000, o_active_div} * 24'h000005;
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   reset_state_a: assert property ($fell(i_rst) |-> o_phase_en == 5'h1e && o_excitation_home_flag
      && !o_closed_loop && o_deviation == 24'h000000) else $error("bad state after reset");
   chopper_gate_a: assert property (!$past(i_rst) |-> o_chopper_switch == !$past(i_sense_above_ref))
      else $error("chopper does not follow comparator");
   phase_count_a: assert property ($countones(o_phase_en) inside {4, 5}) else $error("phase count");
   full_four_a: assert property ((!i_half_step && !i_microstep_en && !o_closed_loop) [*8]
      |-> $countones(o_phase_en) == 4) else $error("full step not four phases");
   div_select_a: assert property ($stable({i_microstep_en, i_div_select, i_div_setting_a, i_div_setting_b}) [*3]
      |-> o_active_div == exp_div) else $error("active division wrong");
   sub_step_a: assert property ($stable(o_active_div) [*2] |-> o_sub_step < o_active_div)
      else $error("sub-step out of range");
   open_loop_a: assert property (($stable(o_deviation) && $stable(o_active_div)) [*2] ##0 dev_mag < thresh
      |-> !o_closed_loop) else $error("closed loop below threshold");
   closed_loop_a: assert property (($stable(o_deviation) && $stable(o_active_div)) [*2] ##0 dev_mag >= thresh
      |-> o_closed_loop) else $error("open loop at threshold");
   step_adv_a: assert property (i_step && i_vf_setting == 4'h0 && !i_microstep_en && !o_closed_loop
      |-> ##[2:4] ($changed(o_phase_en) || o_closed_loop)) else $error("step did not advance");
   dev_count_a: assert property (i_step && !i_rotor_step && i_vf_setting == 4'h0 && !i_microstep_en
      |-> ##[2:4] $changed(o_deviation)) else $error("deviation did not count");
endmodule
bind stepper_excitation_control stepper_excitation_control_chk i_chk (.*);
`default_nettype wire

// [bench/step_pulse_source.sv]
`default_nettype none
module step_pulse_source (
   input wire logic i_core_clk,
   input wire logic i_req,
   input wire logic i_req_dir,
   output logic o_step,
   output logic o_dir
);
   timeunit 1ns;
   timeprecision 1ps;
   // Launching on the falling edge keeps pulse and direction clear of the sampling edge.
   always @(negedge i_core_clk) begin
      o_step <= i_req;
      o_dir <= i_req ? i_req_dir : o_dir;
   end
   initial o_step = 1'b0;
   initial o_dir = 1'b0;
endmodule
`default_nettype wire

// [bench/tb_stepper_excitation_control.sv]
`default_nettype none
`include "stepper_defs.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_total++; \
   $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb_stepper_excitation_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic req = 1'b0, req_dir = 1'b0, half = 1'b0, sel = 1'b0, sense = 1'b0, rstep = 1'b0, rdir = 1'b0;
   logic micro = 1'b0;
   logic [7:0] div_a = 8'h01, div_b = 8'h02;
   logic [3:0] vf = 4'h0;
   wire logic step, dir, chop, home, closed;
   wire logic [4:0] phase_en;
   wire logic [23:0] dev;
   wire logic [7:0] act_div, sub_step;
   integer err_total = 0, total_checks = 0, seed = 57235, idx = 0, dev_m = 0, k;
   integer sub_m = 0, div_m = 1;
   logic [6:0] dirs_a = 7'b0100000;
   always #5 i_core_clk = ~i_core_clk;
   step_pulse_source i_step_pulse_source (.i_core_clk(i_core_clk), .i_req(req), .i_req_dir(req_dir),
      .o_step(step), .o_dir(dir));
   stepper_excitation_control i_stepper_excitation_control (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_step(step), .i_dir(dir), .i_half_step(half), .i_microstep_en(micro), .i_div_setting_a(div_a),
      .i_div_setting_b(div_b), .i_div_select(sel), .i_vf_setting(vf), .i_sense_above_ref(sense),
      .i_rotor_step(rstep), .i_rotor_dir(rdir), .o_phase_en(phase_en), .o_chopper_switch(chop),
      .o_excitation_home_flag(home), .o_closed_loop(closed), .o_deviation(dev), .o_active_div(act_div),
      .o_sub_step(sub_step));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // The model counts commanded minus sensed; a rotor pulse rides two cycles after its step,
   // so the deviation visibly moves and returns instead of cancelling in one edge.
   task automatic pulse(input logic d, input logic s, input logic rot, input integer gap);
      @(negedge i_core_clk);
      req <= s;
      req_dir <= d;
      @(negedge i_core_clk);
      req <= 1'b0;
      repeat (2) @(negedge i_core_clk);
      rstep = rot;
      rdir = d;
      @(negedge i_core_clk);
      rstep = 1'b0;
      if (s && micro) begin
         if (!d) begin
            sub_m = sub_m + 1;
            if (sub_m >= div_m) begin
               sub_m = 0;
               idx = (idx + 2) % 10;
            end
         end else if (sub_m == 0) begin
            sub_m = div_m - 1;
            idx = (idx + 8) % 10;
         end else begin
            sub_m = sub_m - 1;
         end
      end else if (s) begin
         idx = (idx + (d ? -1 : 1) * (half ? 1 : 2) + 10) % 10;
      end
      dev_m = dev_m + ((s ? 1 : 0) - (rot ? 1 : 0)) * (d ? -1 : 1);
      repeat (gap) @(negedge i_core_clk);
   endtask
   task automatic check_state();
      if (dev_m < 5 * (micro ? div_m : 1) && dev_m > -5 * (micro ? div_m : 1)) begin
         `CHK("home", idx == 0 && sub_m == 0, home)
         `CHK("phases", (half && !micro && idx % 2) ? 5 : 4, $countones(phase_en))
      end
      `CHK("sub", sub_m, sub_step)
      `CHK("dev", dev_m, $signed(dev))
      `CHK("closed", dev_m >= 5 * (micro ? div_m : 1) || dev_m <= -5 * (micro ? div_m : 1), closed)
   endtask
   function automatic logic [7:0] clamp(input logic [7:0] v);
      clamp = (v == 8'h00) ? 8'h01 : ((v > 8'hfa) ? 8'hfa : v);
   endfunction
   // A hang is cut off well past the longest expected run of about 20000 cycles.
   initial begin
      #500000;
      err_total++;
      complete_run();
   end
   initial begin
      repeat (16) @(negedge i_core_clk);
      i_rst = 1'b0;
      check_state();
      for (k = 0; k < 7; k++) begin
         pulse(dirs_a[k], 1'b1, 1'b1, 6);
         check_state();
      end
      $display("test full step done");
      half = 1'b1;
      for (k = 0; k < 8; k++) begin
         pulse(1'b0, k < 6, k >= 6, 6);
         check_state();
      end
      $display("test half step and loop mode done");
      for (k = 0; k < 20; k++) begin
         sense = $random(seed);
         repeat (2) @(negedge i_core_clk);
         `CHK("chopper", !sense, chop)
      end
      $display("test chopper done");
      micro = 1'b1;
      for (k = 0; k < 8; k++) begin
         div_a = $random(seed);
         div_b = (k == 0) ? 8'h00 : ((k == 1) ? 8'hff : $random(seed));
         sel = $random(seed);
         repeat (4) @(negedge i_core_clk);
         `CHK("div", clamp(sel ? div_b : div_a), act_div)
      end
      div_a = 8'h03;
      sel = 1'b0;
      div_m = 3;
      $display("test division select done");
      for (k = 0; k < 5; k++) begin
         pulse(k == 3, 1'b1, 1'b1, 6);
         check_state();
      end
      micro = 1'b0;
      div_a = 8'h01;
      $display("test microstep done");
      for (k = 0; k < 16; k++) begin
         vf = k;
         pulse(k % 2, 1'b1, 1'b0, 1100);
         check_state();
      end
      $display("test velocity filter done");
      complete_run();
   end
endmodule
`default_nettype wire
